/* File: dv/dit_cpu_model.sv */
// Purpose: CPU side model, counts edges on the upper timer output pin
// Assumes: Pin level is synchronous to pclk
// Notes:   Counting edges shows a square wave that a level check would miss

`timescale 1ns/10ps

// ****************
// Partner model
// ****************
module dit_cpu_model (
    // Clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // Watched pin
    input  wire logic       upper_output_pin,
    // Edge count
    output logic [7:0]      up_tog
);
    logic prev_q;

    // Count every change of the pin level
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_q <= 1'b0;
            up_tog <= 8'h00;
        end else begin
            prev_q <= upper_output_pin;
            if (prev_q != upper_output_pin) begin
                up_tog <= up_tog + 8'h01;
            end
        end
    end
endmodule : dit_cpu_model

/* File: dv/test_dual_interval_timer_irq.sv */
// Purpose: Self-checking bench of the dual interval timer
// Assumes: One APB wait state, control flags cleared by writing zero, status bits by reading
// Notes:   Count clock select 0 gives a tick every second cycle

`timescale 1ns/10ps

// ****************
// Bench top
// ****************
module test_dual_interval_timer_irq;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = 8'h00, up_tog, t0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic [1:0]  meas_evt = 0, ovf_evt = 0;
    logic        pready, pslverr, slv, lower_output_pin, upper_output_pin;
    logic        irq_lower, irq_upper, irq, lower_output_oe, upper_output_oe;
    int          err_count = 0, n_tests = 0, n;

    dit_timer dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .meas_evt, .ovf_evt, .ext_count_clk(1'b0), .lower_output_pin,
        .lower_output_oe, .upper_output_pin, .upper_output_oe, .irq_lower, .irq_upper, .irq);
    dit_cpu_model cpu_u (.pclk, .presetn, .upper_output_pin, .up_tog);

    // Free running 10 MHz clock
    initial forever #50 pclk = ~pclk;

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e) begin
            err_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk

    // Holds the request until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        slv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 8'h00);
        chk(rd, e);
    endtask : rd_chk

    task automatic pulse(input logic [1:0] m, input logic [1:0] o);
        meas_evt <= m;
        ovf_evt <= o;
        @(posedge pclk);
        meas_evt <= 2'b00;
        ovf_evt <= 2'b00;
        repeat (2) @(posedge pclk);
    endtask : pulse

    task final_report;
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : final_report

    // Watchdog, far beyond the few hundred cycles the tests need
    initial begin
        #2000000;
        err_count++;
        final_report;
    end

    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd_chk(8'h08, 32'h0);
        apb(1'b0, 8'h24, 8'h00);
        chk({slv, rd[30:0]}, 32'h80000000);
        $display("test reset done");
        apb(1'b1, 8'h14, 8'h06);
        apb(1'b1, 8'h00, 8'h80);
        apb(1'b1, 8'h08, 8'ha0);
        apb(1'b1, 8'h14, 8'hf0);
        for (n = 0; n < 40 && irq_lower !== 1'b1; n++) @(posedge pclk);
        chk(irq_lower, 1);
        rd_chk(8'h08, 32'h24);
        chk(lower_output_pin, 1);
        chk(lower_output_oe, 0);
        apb(1'b1, 8'h08, 8'h20);
        chk(irq_lower, 0);
        $display("test one-shot done");
        apb(1'b0, 8'h1c, 8'h00);
        apb(1'b1, 8'h20, 8'h04);
        apb(1'b1, 8'h00, 8'h00);
        pulse(2'b00, 2'b01);
        chk(irq_lower, 0);
        rd_chk(8'h08, 32'h24);
        apb(1'b1, 8'h08, 8'h20);
        pulse(2'b01, 2'b00);
        chk({irq, irq_lower}, 3);
        rd_chk(8'h1c, 32'h14);
        chk(irq, 0);
        apb(1'b1, 8'h08, 8'h00);
        $display("test events done");
        apb(1'b1, 8'h18, 8'h03);
        apb(1'b1, 8'h04, 8'h81);
        apb(1'b1, 8'h0c, 8'ha1);
        for (n = 0; n < 40 && irq_upper !== 1'b1; n++) @(posedge pclk);
        chk(irq_upper, 1);
        rd_chk(8'h0c, 32'ha5);
        chk(upper_output_oe, 1);
        apb(1'b1, 8'h18, 8'h01);
        t0 = up_tog;
        repeat (64) @(posedge pclk);
        chk(8'(up_tog - t0) >= 8'd12, 1);
        apb(1'b1, 8'h0c, 8'h00);
        // A match in the stop cycle wins over the clear; clear again once stopped
        apb(1'b1, 8'h0c, 8'h00);
        t0 = up_tog;
        repeat (30) @(posedge pclk);
        chk({irq_upper, up_tog}, {1'b0, t0});
        $display("test continuous done");
        apb(1'b1, 8'h0c, 8'h20);
        apb(1'b1, 8'h10, 8'h10);
        pulse(2'b10, 2'b00);
        chk(irq_upper, 0);
        apb(1'b1, 8'h10, 8'h00);
        pulse(2'b10, 2'b00);
        chk(irq_upper, 1);
        $display("test wide done");
        final_report;
    end
endmodule : test_dual_interval_timer_irq

/* File: hw/dit_half.sv */
// Purpose: One counter half with compare latch
// Assumes: Restart and increment come from the same clock domain
// Notes:   Restart clears the count and reloads the latch together

`timescale 1ns/10ps

// ****************************************************************
// Counter half
// ****************************************************************
module dit_half #(
    parameter int W = 8
) (
    // Clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // Control
    input  wire logic         inc,
    input  wire logic         restart,
    input  wire logic [W-1:0] din,
    // State
    output logic [W-1:0]      cnt,
    output logic              eq,
    output logic              top
);

    logic [W-1:0] cnt_q, cnt_d;
    logic [W-1:0] lat_q, lat_d;

    always_comb begin
        cnt_d = cnt_q;
        lat_d = lat_q;
        if (restart) begin
            cnt_d = '0;
            lat_d = din;
        end else if (inc) begin
            cnt_d = cnt_q + 1'b1;
        end
    end

    // Count and latch registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= '0;
            lat_q <= '0;
        end else begin
            cnt_q <= cnt_d;
            lat_q <= lat_d;
        end
    end

    // Compare against the latch, never the live data register
    assign cnt = cnt_q;
    assign eq  = (cnt_q == lat_q);
    assign top = &cnt_q;

    property p_restart_zero;
        @(posedge pclk) disable iff (!presetn)
        restart |=> (cnt_q == '0 && lat_q == $past(din));
    endproperty
    a_restart_zero: assert property (p_restart_zero)
        else $error("restart did not zero counter and load latch");

    property p_latch_hold;
        @(posedge pclk) disable iff (!presetn)
        !restart |=> (lat_q == $past(lat_q));
    endproperty
    a_latch_hold: assert property (p_latch_hold)
        else $error("compare latch changed without restart");

endmodule : dit_half

/* File: hw/dit_pkg.sv */
// Purpose: Shared constants and carriers of the dual interval timer
// Assumes: APB with 32-bit data, one aligned word per register
// Notes:   Registers are 8 bits wide, status and mask 6, and sit in the low byte of a word

// ****************************************************************
// Package
// ****************************************************************
package dit_pkg;

    // Bus and register widths
    localparam int ADDR_W = 8;
    localparam int REG_W  = 8;
    localparam int STAT_W = 6;
    localparam int DIV_W  = 8;

    // Register byte addresses
    localparam logic [ADDR_W-1:0] ADDR_CTRL0_LO = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_CTRL0_HI = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_CTRL1_LO = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_CTRL1_HI = 8'h0c;
    localparam logic [ADDR_W-1:0] ADDR_PAIR     = 8'h10;
    localparam logic [ADDR_W-1:0] ADDR_DATA_LO  = 8'h14;
    localparam logic [ADDR_W-1:0] ADDR_DATA_HI  = 8'h18;
    localparam logic [ADDR_W-1:0] ADDR_STAT     = 8'h1c;
    localparam logic [ADDR_W-1:0] ADDR_MASK     = 8'h20;

    // Reset values
    localparam logic [REG_W-1:0]  CTRL0_RST = 8'h00;
    localparam logic [REG_W-1:0]  CTRL1_RST = 8'h00;
    localparam logic [REG_W-1:0]  PAIR_RST  = 8'h00;
    localparam logic [REG_W-1:0]  DATA_RST  = 8'h00;
    localparam logic [STAT_W-1:0] STAT_RST  = 6'h00;
    localparam logic [STAT_W-1:0] MASK_RST  = 6'h00;

    // Status bit positions: match, measurement, overflow per half
    localparam int ST_MATCH = 0;
    localparam int ST_MEAS  = 2;
    localparam int ST_OVF   = 4;

    // Function field codes handled here
    typedef enum logic [3:0] {
        DIT_FN_ONESHOT = 4'h0,
        DIT_FN_CONT    = 4'h1
    } dit_func_t;

    // Mode select register
    typedef struct packed {
        logic       match_flag_irq_enable;
        logic [2:0] clk_sel;
        logic [3:0] func;
    } dit_ctrl0_t;

    // Run and flag register
    typedef struct packed {
        logic run_bit;
        logic hold_bit;
        logic irq_enable;
        logic measure_flag;
        logic buf_flag;
        logic match_flag;
        logic init_out;
        logic out_en;
    } dit_ctrl1_t;

    // Pair mode register
    typedef struct packed {
        logic       upper_output_bit;
        logic       lower_output_bit;
        logic       input_sel;
        logic       width_select;
        logic [3:0] filter_sel;
    } dit_pair_t;

endpackage : dit_pkg

/* File: hw/dit_tick_sel.sv */
// Purpose: Count clock selector, one tick per rising source edge
// Assumes: Sources are synchronous to pclk
// Notes:   Tick is a one-cycle pulse

`timescale 1ns/10ps

// ****************************************************************
// Tick selector
// ****************************************************************
module dit_tick_sel #(
    parameter int N = 8
) (
    // Clock and reset
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    // Sources and select
    input  wire logic [N-1:0]         src,
    input  wire logic [$clog2(N)-1:0] sel,
    // Count tick
    output logic                      tick
);

    logic prev_q;
    logic prev_d;

    always_comb begin
        prev_d = src[sel];
        tick   = src[sel] & ~prev_q;
    end

    // Previous level of the chosen source
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_q <= 1'b0;
        end else begin
            prev_q <= prev_d;
        end
    end

    property p_tick_rise;
        @(posedge pclk) disable iff (!presetn)
        tick |-> (src[sel] && !$past(src[sel]) && $stable(sel));
    endproperty
    a_tick_rise: assert property (p_tick_rise)
        else $error("tick without rising edge of selected source");

endmodule : dit_tick_sel

/* File: hw/dit_timer.sv */
// Purpose: Dual 8-bit interval timer channel with APB registers
// Assumes: Capture and measurement events arrive from pclk logic
// Notes:   One APB wait state; control flags clear by writing zero, status bits clear on read
//
// The address map and register access over APB were chosen for this implementation.

`timescale 1ns/10ps

// ****************************************************************
// Top
// ****************************************************************
module dit_timer (
    // Clock and reset
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    // APB slave
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [dit_pkg::ADDR_W-1:0]  paddr,
    input  wire logic [31:0]                 pwdata,
    output logic      [31:0]                 prdata,
    output logic                             pready,
    output logic                             pslverr,
    // Capture logic events, one bit per half
    input  wire logic [1:0]                  meas_evt,
    input  wire logic [1:0]                  ovf_evt,
    // External count clock pin
    input  wire logic                        ext_count_clk,
    // Timer output pins
    output logic                             lower_output_pin,
    output logic                             lower_output_oe,
    output logic                             upper_output_pin,
    output logic                             upper_output_oe,
    // Interrupts
    output logic                             irq_lower,
    output logic                             irq_upper,
    output logic                             irq
);

    // ************************************************************
    // State
    // ************************************************************
    dit_pkg::dit_ctrl0_t              ctrl0_q [2], ctrl0_d [2];
    dit_pkg::dit_ctrl1_t              ctrl1_q [2], ctrl1_d [2];
    dit_pkg::dit_pair_t               pair_q, pair_d;
    logic [dit_pkg::REG_W-1:0]        data_q [2], data_d [2];
    logic [dit_pkg::STAT_W-1:0]       stat_q, stat_d, mask_q, mask_d;
    logic [dit_pkg::DIV_W-1:0]        div_q, div_d;
    logic                             ext_s1_q, ext_s2_q;
    logic [31:0]                      prdata_d;
    logic                             pready_d, pslverr_d;
    logic                             irq_lower_d, irq_upper_d, irq_d;
    logic                             acc, done, wr, rd, hit;
    logic [dit_pkg::REG_W-1:0]        rb;
    logic [1:0]                       wr_c0, wr_c1, wr_dat;
    logic [1:0]                       start, inc, restart, match, tick, eq, top;
    logic [1:0]                       fok, cont, oneshot, ev_meas, ev_ovf;
    logic                             wide;
    logic [dit_pkg::REG_W-1:0]        cnt [2];
    dit_pkg::dit_ctrl1_t              wc1;
    logic [dit_pkg::DIV_W-1:0]        src;

    // ************************************************************
    // APB decode
    // ************************************************************

    // Access completes on the second access cycle
    always_comb begin
        acc       = psel & penable & ~pready;
        done      = psel & penable & pready;
        wr        = done & pwrite;
        rd        = done & ~pwrite;
        wc1       = dit_pkg::dit_ctrl1_t'(pwdata[7:0]);
        wr_c0[0]  = wr & (paddr == dit_pkg::ADDR_CTRL0_LO);
        wr_c0[1]  = wr & (paddr == dit_pkg::ADDR_CTRL0_HI);
        wr_c1[0]  = wr & (paddr == dit_pkg::ADDR_CTRL1_LO);
        wr_c1[1]  = wr & (paddr == dit_pkg::ADDR_CTRL1_HI);
        wr_dat[0] = wr & (paddr == dit_pkg::ADDR_DATA_LO);
        wr_dat[1] = wr & (paddr == dit_pkg::ADDR_DATA_HI);
    end

    // Read mux; unmapped addresses answer with an error
    always_comb begin
        hit = 1'b1;
        rb  = '0;
        unique case (paddr)
            dit_pkg::ADDR_CTRL0_LO: rb = ctrl0_q[0];
            dit_pkg::ADDR_CTRL0_HI: rb = ctrl0_q[1];
            dit_pkg::ADDR_CTRL1_LO: rb = ctrl1_q[0];
            dit_pkg::ADDR_CTRL1_HI: rb = ctrl1_q[1];
            dit_pkg::ADDR_PAIR:     rb = pair_q;
            dit_pkg::ADDR_DATA_LO:  rb = data_q[0];
            dit_pkg::ADDR_DATA_HI:  rb = data_q[1];
            dit_pkg::ADDR_STAT:     rb = {2'b00, stat_q};
            dit_pkg::ADDR_MASK:     rb = {2'b00, mask_q};
            default:                hit = 1'b0;
        endcase
        pready_d  = acc;
        pslverr_d = acc & ~hit;
        prdata_d  = (acc & ~pwrite) ? {24'h000000, rb} : prdata;
    end

    // ************************************************************
    // Count clocks and counters
    // ************************************************************

    // Prescaler taps plus synchronised external clock on the top tap
    always_comb begin
        div_d = div_q + 1'b1;
        src   = {ext_s2_q, div_q[dit_pkg::DIV_W-2:0]};
    end

    // Counting control for both halves
    always_comb begin
        wide = pair_q.width_select;
        for (int h = 0; h < 2; h++) begin
            cont[h]    = (ctrl0_q[h].func == dit_pkg::DIT_FN_CONT);
            oneshot[h] = (ctrl0_q[h].func == dit_pkg::DIT_FN_ONESHOT);
            fok[h]     = cont[h] | oneshot[h];
            start[h]   = wr_c1[h] & wc1.run_bit & ~ctrl1_q[h].run_bit;
        end
        inc[0] = tick[0] & ctrl1_q[0].run_bit & fok[0] & ~start[0];
        inc[1] = wide ? (inc[0] & top[0])
                      : (tick[1] & ctrl1_q[1].run_bit & fok[1] & ~start[1]);
        match[0] = inc[0] & eq[0] & (~wide | eq[1]);
        match[1] = ~wide & inc[1] & eq[1];
        restart[0] = start[0] | (match[0] & cont[0]);
        restart[1] = wide ? restart[0] : (start[1] | (match[1] & cont[1]));
        ev_meas = {meas_evt[1] & ~wide, meas_evt[0]};
        ev_ovf  = {ovf_evt[1] & ~wide, ovf_evt[0]};
    end

    // Two halves, each with its own clock select
    for (genvar g = 0; g < 2; g++) begin : g_half
        dit_tick_sel #(.N(dit_pkg::DIV_W)) u_tick (
            .pclk    (pclk),
            .presetn (presetn),
            .src     (src),
            .sel     (ctrl0_q[g].clk_sel),
            .tick    (tick[g])
        );
        dit_half #(.W(dit_pkg::REG_W)) u_half (
            .pclk    (pclk),
            .presetn (presetn),
            .inc     (inc[g]),
            .restart (restart[g]),
            .din     (data_q[g]),
            .cnt     (cnt[g]),
            .eq      (eq[g]),
            .top     (top[g])
        );
    end

    // ************************************************************
    // Registers, flags and outputs
    // ************************************************************

    // Register next values; hardware sets win over software clears
    always_comb begin
        pair_d = pair_q;
        mask_d = mask_q;
        for (int h = 0; h < 2; h++) begin
            ctrl0_d[h] = wr_c0[h] ? dit_pkg::dit_ctrl0_t'(pwdata[7:0]) : ctrl0_q[h];
            data_d[h]  = wr_dat[h] ? pwdata[7:0] : data_q[h];
            ctrl1_d[h] = ctrl1_q[h];
            if (wr_c1[h]) begin
                ctrl1_d[h].run_bit    = wc1.run_bit;
                ctrl1_d[h].hold_bit   = wc1.hold_bit;
                ctrl1_d[h].irq_enable = wc1.irq_enable;
                ctrl1_d[h].init_out   = wc1.init_out;
                ctrl1_d[h].out_en     = wc1.out_en;
                ctrl1_d[h].measure_flag = ctrl1_q[h].measure_flag & wc1.measure_flag;
                ctrl1_d[h].match_flag   = ctrl1_q[h].match_flag & wc1.match_flag;
            end
            ctrl1_d[h].buf_flag = 1'b0;
            if (match[h] & oneshot[h]) begin
                ctrl1_d[h].run_bit = 1'b0;
            end
            ctrl1_d[h].match_flag   = ctrl1_d[h].match_flag | match[h] | ev_ovf[h];
            ctrl1_d[h].measure_flag = ctrl1_d[h].measure_flag | ev_meas[h];
        end
        if (wr & (paddr == dit_pkg::ADDR_PAIR)) begin
            pair_d.input_sel    = pwdata[5];
            pair_d.width_select = pwdata[4];
            pair_d.filter_sel   = pwdata[3:0];
        end
        if (start[0]) pair_d.lower_output_bit = ctrl1_q[0].init_out;
        else if (match[0]) pair_d.lower_output_bit = ~pair_q.lower_output_bit;
        if (start[1] & ~wide) pair_d.upper_output_bit = ctrl1_q[1].init_out;
        else if (match[1]) pair_d.upper_output_bit = ~pair_q.upper_output_bit;
        if (wr & (paddr == dit_pkg::ADDR_MASK)) mask_d = pwdata[5:0];
        // Clear only bits the reader saw, so a late event survives
        stat_d = (stat_q & ~(rd & (paddr == dit_pkg::ADDR_STAT) ? prdata[5:0] : 6'h00))
               | {ev_ovf, ev_meas, match};
        irq_lower_d = ctrl1_d[0].irq_enable & (ctrl1_d[0].measure_flag
                    | (ctrl0_d[0].match_flag_irq_enable & ctrl1_d[0].match_flag));
        irq_upper_d = ~pair_d.width_select & ctrl1_d[1].irq_enable
                    & (ctrl1_d[1].measure_flag
                    | (ctrl0_d[1].match_flag_irq_enable & ctrl1_d[1].match_flag));
        irq_d = |(stat_d & mask_d);
    end

    // All top-level state registers; counters and tick edges live in the halves
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int h = 0; h < 2; h++) begin
                ctrl0_q[h] <= dit_pkg::CTRL0_RST;
                ctrl1_q[h] <= dit_pkg::CTRL1_RST;
                data_q[h]  <= dit_pkg::DATA_RST;
            end
            pair_q           <= dit_pkg::PAIR_RST;
            stat_q           <= dit_pkg::STAT_RST;
            mask_q           <= dit_pkg::MASK_RST;
            div_q            <= '0;
            ext_s1_q         <= 1'b0;
            ext_s2_q         <= 1'b0;
            prdata           <= 32'h00000000;
            pready           <= 1'b0;
            pslverr          <= 1'b0;
            irq_lower        <= 1'b0;
            irq_upper        <= 1'b0;
            irq              <= 1'b0;
            lower_output_pin <= 1'b0;
            lower_output_oe  <= 1'b0;
            upper_output_pin <= 1'b0;
            upper_output_oe  <= 1'b0;
        end else begin
            for (int h = 0; h < 2; h++) begin
                ctrl0_q[h] <= ctrl0_d[h];
                ctrl1_q[h] <= ctrl1_d[h];
                data_q[h]  <= data_d[h];
            end
            pair_q           <= pair_d;
            stat_q           <= stat_d;
            mask_q           <= mask_d;
            div_q            <= div_d;
            ext_s1_q         <= ext_count_clk;
            ext_s2_q         <= ext_s1_q;
            prdata           <= prdata_d;
            pready           <= pready_d;
            pslverr          <= pslverr_d;
            irq_lower        <= irq_lower_d;
            irq_upper        <= irq_upper_d;
            irq              <= irq_d;
            lower_output_pin <= pair_d.lower_output_bit;
            lower_output_oe  <= ctrl1_d[0].out_en;
            upper_output_pin <= pair_d.upper_output_bit;
            upper_output_oe  <= ctrl1_d[1].out_en;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************

    property p_lower_req;
        @(posedge pclk) disable iff (!presetn)
        (ctrl1_q[0].match_flag && ctrl1_q[0].irq_enable
         && ctrl0_q[0].match_flag_irq_enable) |-> irq_lower;
    endproperty
    a_lower_req: assert property (p_lower_req)
        else $error("lower match request missing");

    property p_meas_req;
        @(posedge pclk) disable iff (!presetn)
        $rose(ctrl1_q[1].measure_flag) && ctrl1_q[1].irq_enable && !wide
        |-> irq_upper;
    endproperty
    a_meas_req: assert property (p_meas_req)
        else $error("upper measurement request missing");

    property p_upper_quiet;
        @(posedge pclk) disable iff (!presetn)
        wide |-> !irq_upper;
    endproperty
    a_upper_quiet: assert property (p_upper_quiet)
        else $error("upper request in 16-bit mode");

    property p_oneshot_halt;
        @(posedge pclk) disable iff (!presetn)
        (match[0] && oneshot[0] && !wr_c1[0]) |=> (!ctrl1_q[0].run_bit
        && ctrl1_q[0].match_flag && pair_q.lower_output_bit != $past(pair_q.lower_output_bit));
    endproperty
    a_oneshot_halt: assert property (p_oneshot_halt)
        else $error("one-shot match did not halt and toggle");

    property p_cont_wrap;
        @(posedge pclk) disable iff (!presetn)
        (match[1] && cont[1] && !start[1] && !wr_c1[1]) |=> (cnt[1] == 8'h00
        && ctrl1_q[1].match_flag && ctrl1_q[1].run_bit);
    endproperty
    a_cont_wrap: assert property (p_cont_wrap)
        else $error("continuous match did not wrap counter");

    property p_out_hold;
        @(posedge pclk) disable iff (!presetn)
        (!ctrl1_q[0].run_bit && !start[0]) |=> $stable(pair_q.lower_output_bit);
    endproperty
    a_out_hold: assert property (p_out_hold)
        else $error("output changed while stopped");

    property p_flag_stick;
        @(posedge pclk) disable iff (!presetn)
        (ctrl1_q[0].match_flag && !(wr_c1[0] && !wc1.match_flag))
        |=> ctrl1_q[0].match_flag;
    endproperty
    a_flag_stick: assert property (p_flag_stick)
        else $error("match flag dropped without clear");

    // in 16-bit mode, upper counts only on lower carry
    property p_carry;
        @(posedge pclk) disable iff (!presetn)
        (wide && inc[1]) |-> (inc[0] && cnt[0] == 8'hff);
    endproperty
    a_carry: assert property (p_carry)
        else $error("upper half counted without carry");

endmodule : dit_timer
